// ---- common/ilvc_pkg.sv ----
package ilvc_pkg;
    // source counts and widths
    localparam int NUM_HW = 16;
    localparam int NUM_SW = 2;
    localparam int NUM_SRC = NUM_HW + NUM_SW;
    localparam int MAX_SRC = 32;
    localparam int VEC_W = 64;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 5;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_PENDING = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_ENABLE = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_ACK = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_VEC_INDEX = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_MASTER = 12'h01C;
    localparam logic [ADDR_W-1:0] OFS_FAST_SEL = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_THRESHOLD = 12'h024;
    // vector windows, selected by address bits [11:8]
    localparam logic [3:0] PAGE_VEC32 = 4'h1;
    localparam logic [3:0] PAGE_VEC64 = 4'h2;

    // master control fields
    localparam int MC_REQ_OUT_EN = 0;
    localparam int MC_HW_IN_EN = 1;

    // reset values
    localparam logic [31:0] THRESHOLD_RST = 32'h0FFFFFFF;
    localparam logic [31:0] NO_VECTOR = 32'hFFFFFFFF;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- design/ilvc_ctrl.sv ----
// What this block does
// RULE_01: a source may request only when its ordinal is below the threshold.
// RULE_02: the priority threshold register is readable and writable.
// RULE_03: the priority threshold resets to all ones, allowing every source; here it resets to 0FFFFFFF, which still allows all 18.
// RULE_04: one vector register per hardware source plus one per soft source.
// RULE_05: standard vector registers are 32 bits, extended ones 64 bits wide.
// RULE_06: the winning source's stored address goes out with the request.
// RULE_07: software gives normal-mode sources the processor's normal vector.
// RULE_08: unused vector locations read zero and ignore writes.
// RULE_09: software rewrites a vector only while its source is disabled.
// RULE_10: one bus clock; the request output is retimed by an output flop.
// RULE_11: one reset serves the whole block, processor side included.
// RULE_12: after reset inputs and the request output are disabled.
// RULE_13: software sets enable bits; source zero, bit zero, ranks highest.
// RULE_14: software sets the output enable before any request appears.
// RULE_15: while input enable is low, writing pending bits creates requests.
// RULE_16: input enable is write-once and stops software hardware requests.
// RULE_17: master control has output enable in bit 0, input enable in bit 1.
// RULE_18: a set fast mode select bit handles that source in fast mode.
// RULE_19: a blocked source stays pending and fires once the threshold rises.
module ilvc_ctrl (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // interrupt sources
    input wire logic [ilvc_pkg::NUM_HW-1:0] hw_irq,
    // axi4-lite write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ilvc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ilvc_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // processor side
    output logic irq,
    output logic irq_fast,
    output logic [ilvc_pkg::VEC_W-1:0] vec_addr
);
    localparam int N = ilvc_pkg::NUM_SRC;

    // ====================================================
    // state
    logic [N-1:0] pending_status_reg;
    logic [N-1:0] enable_mask_reg;
    logic [N-1:0] fast_mode_select_reg;
    logic [31:0] priority_threshold_reg;
    logic request_output_enable_reg;
    logic hw_input_enable_reg;
    logic [ilvc_pkg::VEC_W-1:0] vec_mem [N];
    logic bvalid_reg, rvalid_reg, irq_reg, fast_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [ilvc_pkg::VEC_W-1:0] vec_out_reg;

    // merge write data under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ====================================================
    // write channel: address and data taken together, one at a time
    logic wr_go;
    logic [31:0] wd;
    logic [ilvc_pkg::ADDR_W-1:0] wa;
    logic [3:0] wpage;
    logic [4:0] w32_idx, w64_idx;
    logic w32_hit, w64_hit, w_known;
    logic aw_rdy_reg;
    assign wr_go = aw_rdy_reg && s_axi_awvalid && s_axi_wvalid;
    assign wa = s_axi_awaddr;
    assign wd = s_axi_wdata;
    assign wpage = wa[11:8];
    assign w32_idx = wa[6:2];
    assign w64_idx = wa[7:3];
    // unused slots up to 32 decode but store nothing
    assign w32_hit = wpage == ilvc_pkg::PAGE_VEC32
                     && wa[7] == 1'b0 && wa[1:0] == 2'h0;
    assign w64_hit = wpage == ilvc_pkg::PAGE_VEC64 && wa[1:0] == 2'h0;
    assign w_known = w32_hit || w64_hit
                     || wa == ilvc_pkg::OFS_PENDING
                     || wa == ilvc_pkg::OFS_ENABLE
                     || wa == ilvc_pkg::OFS_ACK
                     || wa == ilvc_pkg::OFS_VEC_INDEX
                     || wa == ilvc_pkg::OFS_MASTER
                     || wa == ilvc_pkg::OFS_FAST_SEL
                     || wa == ilvc_pkg::OFS_THRESHOLD;

    // ready is a flop so the port stays glitch free; costs one cycle a write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aw_rdy_reg <= 1'b0;
        end else begin
            aw_rdy_reg <= s_axi_awvalid && s_axi_wvalid && !aw_rdy_reg
                          && !bvalid_reg;
        end
    end

    // write response, held until accepted
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= ilvc_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= w_known ? ilvc_pkg::RESP_OKAY
                                 : ilvc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ====================================================
    // control registers
    logic [31:0] wd_m;
    assign wd_m = merge(32'h0, wd, s_axi_wstrb);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            enable_mask_reg <= '0; // RULE_12
            fast_mode_select_reg <= '0;
            priority_threshold_reg <= ilvc_pkg::THRESHOLD_RST; // RULE_03
            request_output_enable_reg <= 1'b0; // RULE_12
            hw_input_enable_reg <= 1'b0;
        end else if (wr_go) begin
            if (wa == ilvc_pkg::OFS_ENABLE) begin
                enable_mask_reg <= N'(merge(32'(enable_mask_reg), wd,
                                            s_axi_wstrb));
            end
            if (wa == ilvc_pkg::OFS_FAST_SEL) begin
                fast_mode_select_reg <= N'(merge(32'(fast_mode_select_reg),
                                                 wd, s_axi_wstrb)); // RULE_18
            end
            if (wa == ilvc_pkg::OFS_THRESHOLD) begin
                priority_threshold_reg <= merge(priority_threshold_reg,
                                                wd, s_axi_wstrb); // RULE_02
            end
            if (wa == ilvc_pkg::OFS_MASTER && s_axi_wstrb[0]) begin
                request_output_enable_reg <=
                    wd[ilvc_pkg::MC_REQ_OUT_EN]; // RULE_17
                // once set it sticks until reset
                if (wd[ilvc_pkg::MC_HW_IN_EN]) begin
                    hw_input_enable_reg <= 1'b1; // RULE_16
                end
            end
        end
    end

    // ====================================================
    // pending bits: hardware set wins over an acknowledge
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_src
            logic hw_set, sw_set, clr;
            if (gi < ilvc_pkg::NUM_HW) begin : g_hw
                assign hw_set = hw_input_enable_reg && hw_irq[gi];
                // software may set only before hardware inputs go live
                assign sw_set = !hw_input_enable_reg; // RULE_15
            end else begin : g_sw
                assign hw_set = 1'b0;
                // soft sources stay writable for good
                assign sw_set = 1'b1; // RULE_16
            end
            assign clr = wr_go && wa == ilvc_pkg::OFS_ACK && wd_m[gi];
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    pending_status_reg[gi] <= 1'b0;
                end else if (hw_set || (sw_set && wr_go && wd_m[gi]
                             && wa == ilvc_pkg::OFS_PENDING)) begin
                    pending_status_reg[gi] <= 1'b1; // RULE_15
                end else if (clr) begin
                    pending_status_reg[gi] <= 1'b0; // RULE_19
                end
            end
        end
    endgenerate

    // ====================================================
    // vector address store, only slots of existing sources
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                vec_mem[i] <= '0;
            end
        end else if (wr_go) begin
            if (w32_hit && 32'(w32_idx) < N) begin // RULE_08
                vec_mem[w32_idx][31:0] <= merge(vec_mem[w32_idx][31:0],
                                                wd, s_axi_wstrb); // RULE_05
            end
            if (w64_hit && 32'(w64_idx) < N) begin // RULE_04
                if (wa[2]) begin
                    vec_mem[w64_idx][63:32] <= merge(vec_mem[w64_idx][63:32],
                                                     wd, s_axi_wstrb);
                end else begin
                    vec_mem[w64_idx][31:0] <= merge(vec_mem[w64_idx][31:0],
                                                    wd, s_axi_wstrb);
                end
            end
        end
    end

    // ====================================================
    // priority pick: lowest enabled pending ordinal under threshold
    logic found;
    logic [ilvc_pkg::IDX_W-1:0] win;
    always_comb begin
        found = 1'b0;
        win = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pending_status_reg[i] && enable_mask_reg[i]
                && 32'(i) < priority_threshold_reg) begin // RULE_01
                found = 1'b1;
                win = ilvc_pkg::IDX_W'(i);
            end
        end
    end

    // request and vector registered together so they arrive as a pair
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_reg <= 1'b0; // RULE_11
            fast_reg <= 1'b0;
            vec_out_reg <= '0;
        end else begin
            irq_reg <= found && request_output_enable_reg; // RULE_10
            fast_reg <= found && fast_mode_select_reg[win];
            vec_out_reg <= found ? vec_mem[win] : '0; // RULE_06
        end
    end

    // ====================================================
    // read channel
    logic rd_go;
    logic [ilvc_pkg::ADDR_W-1:0] ra;
    logic [4:0] r32_idx, r64_idx;
    logic r32_hit, r64_hit;
    logic [31:0] rd_val;
    logic rd_ok;
    logic ar_rdy_reg;
    assign rd_go = ar_rdy_reg && s_axi_arvalid;
    // read ready offered for one cycle once no data is waiting
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ar_rdy_reg <= 1'b0;
        end else begin
            ar_rdy_reg <= s_axi_arvalid && !ar_rdy_reg && !rvalid_reg;
        end
    end
    assign ra = s_axi_araddr;
    assign r32_idx = ra[6:2];
    assign r64_idx = ra[7:3];
    assign r32_hit = ra[11:8] == ilvc_pkg::PAGE_VEC32
                     && ra[7] == 1'b0 && ra[1:0] == 2'h0;
    assign r64_hit = ra[11:8] == ilvc_pkg::PAGE_VEC64 && ra[1:0] == 2'h0;
    always_comb begin
        rd_val = 32'h0;
        rd_ok = 1'b1;
        if (r32_hit) begin
            if (32'(r32_idx) < N) begin
                rd_val = vec_mem[r32_idx][31:0];
            end
        end else if (r64_hit) begin
            if (32'(r64_idx) < N) begin
                rd_val = ra[2] ? vec_mem[r64_idx][63:32]
                               : vec_mem[r64_idx][31:0];
            end
        end else begin
            case (ra)
                ilvc_pkg::OFS_PENDING: rd_val = 32'(pending_status_reg);
                ilvc_pkg::OFS_ENABLE: rd_val = 32'(enable_mask_reg);
                ilvc_pkg::OFS_ACK: rd_val = 32'h0;
                ilvc_pkg::OFS_VEC_INDEX:
                    rd_val = found ? 32'(win) : ilvc_pkg::NO_VECTOR;
                ilvc_pkg::OFS_MASTER:
                    rd_val = {30'h0, hw_input_enable_reg,
                              request_output_enable_reg}; // RULE_17
                ilvc_pkg::OFS_FAST_SEL: rd_val = 32'(fast_mode_select_reg);
                ilvc_pkg::OFS_THRESHOLD: rd_val = priority_threshold_reg;
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // read data held until accepted
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= ilvc_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_val;
            rresp_reg <= rd_ok ? ilvc_pkg::RESP_OKAY
                               : ilvc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ====================================================
    // outputs, every one straight from a flop
    assign s_axi_awready = aw_rdy_reg;
    assign s_axi_wready = aw_rdy_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = ar_rdy_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign irq = irq_reg;
    assign irq_fast = fast_reg;
    assign vec_addr = vec_out_reg;
endmodule

// ---- tb/ilvc_chk.sv ----
// ==========
// port checker
module ilvc_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [ilvc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [ilvc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // processor side
    input wire logic irq,
    input wire logic irq_fast,
    input wire logic [ilvc_pkg::VEC_W-1:0] vec_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // a write counts once address and data meet the ready
    wire logic wr_take = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
    wire logic rd_take = s_axi_arvalid && s_axi_arready;
    property p_wr_ans;
        wr_take |=> s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans)
        else $error("write unanswered");
    property p_rd_ans;
        rd_take |=> s_axi_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read unanswered");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved");
    property p_rst_clr;
        $fell(rst) |-> !irq && !irq_fast && vec_addr == '0 && !s_axi_bvalid;
    endproperty
    a_rst_clr: assert property (p_rst_clr)
        else $error("outputs after reset");
    // only the 32 slots of the standard window; above them is unmapped
    property p_unused;
        rd_take && s_axi_araddr[11:8] == ilvc_pkg::PAGE_VEC32
            && s_axi_araddr[7] == 1'b0
            && s_axi_araddr[6:2] >= 5'(ilvc_pkg::NUM_SRC)
            |=> s_axi_rdata == 32'h0 && s_axi_rresp == ilvc_pkg::RESP_OKAY;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused slot read");
    property p_mc_zero;
        rd_take && s_axi_araddr == ilvc_pkg::OFS_MASTER
            |=> s_axi_rdata[31:2] == '0;
    endproperty
    a_mc_zero: assert property (p_mc_zero)
        else $error("master upper bits");
    // the new threshold lands at the take edge, irq follows one cycle later
    property p_thr0;
        wr_take && s_axi_awaddr == ilvc_pkg::OFS_THRESHOLD
            && s_axi_wdata == 32'h0 && s_axi_wstrb == 4'hF |-> ##2 !irq [*2];
    endproperty
    a_thr0: assert property (p_thr0)
        else $error("irq past zero threshold");
    property p_roe0;
        wr_take && s_axi_awaddr == ilvc_pkg::OFS_MASTER && !s_axi_wdata[0]
            && s_axi_wstrb[0] |-> ##2 !irq [*2];
    endproperty
    a_roe0: assert property (p_roe0)
        else $error("irq with output off");
endmodule

bind ilvc_ctrl ilvc_chk ilvc_chk_inst (.*);

// ---- tb/ilvc_cpu.sv ----
// ==========
// processor core: latches the handler address on each new request
module ilvc_cpu (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // request from the controller
    input wire logic irq,
    input wire logic [ilvc_pkg::VEC_W-1:0] vec_addr,
    // where the core jumped
    output logic [ilvc_pkg::VEC_W-1:0] jump_reg
);
    timeunit 1ns;
    timeprecision 100ps;
    logic irq_reg;
    // the address is taken with the request edge, as a jump would;
    // slots hold the random words the test wrote; nothing here checks that the jump is valid
    always_ff @(posedge core_clk) begin
        irq_reg <= rst ? 1'b0 : irq;
        if (rst) begin
            jump_reg <= '0;
        end else if (irq && !irq_reg) begin
            jump_reg <= vec_addr;
        end
    end
endmodule

// ---- tb/interrupt_level_vector_ctrl_tb.sv ----
module interrupt_level_vector_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // signals
    logic core_clk = 1'b0, rst = 1'b1, s_axi_bready = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic [ilvc_pkg::NUM_HW-1:0] hw_irq = '0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_arready, s_axi_rvalid, irq, irq_fast;
    logic [63:0] vec_addr, jump_reg;
    logic [31:0] m_thr, m_en, m_pend, m_fast;
    logic m_roe, m_hie;
    logic [63:0] m_vec [32];
    int miscompares = 0, n_checks = 0, cycles = 0;
    ilvc_ctrl ilvc_ctrl_inst (.*);
    ilvc_cpu ilvc_cpu_inst (.*);
    always #2.5 core_clk = ~core_clk;
    // level sources set pending every cycle once inputs are on
    always @(posedge core_clk) if (m_hie) m_pend |= 32'(hw_irq);
    // a hang is cut short well beyond the expected run
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            test_done();
        end
    end
    // ==========
    // model and helpers
    task automatic test_done();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(logic [63:0] got, logic [63:0] exp, string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s %h/%h", $time, what, got, exp);
        end
    endtask
    // winner under the threshold, 32 when nothing may request
    function automatic int m_win();
        int w;
        w = 32;
        for (int i = 31; i >= 0; i--) if (m_pend[i] && m_en[i]) w = i;
        return w < m_thr ? w : 32;
    endfunction
    function automatic void m_wr(logic [11:0] a, logic [31:0] d);
        logic [31:0] k;
        logic [31:0] sw_ok;
        for (int b = 0; b < 4; b++) k[8*b+:8] = {8{s_axi_wstrb[b]}};
        sw_ok = m_hie ? 32'h30000 : 32'h3FFFF;
        case (a)
            ilvc_pkg::OFS_PENDING: m_pend |= d & sw_ok;
            ilvc_pkg::OFS_ENABLE: m_en = d & 32'h3FFFF;
            ilvc_pkg::OFS_ACK: m_pend &= ~d;
            ilvc_pkg::OFS_MASTER: m_roe = d[0];
            ilvc_pkg::OFS_FAST_SEL: m_fast = d & 32'h3FFFF;
            ilvc_pkg::OFS_THRESHOLD: m_thr = (m_thr & ~k) | (d & k);
            default: ;
        endcase
        if (a == ilvc_pkg::OFS_MASTER) m_hie |= d[1];
        if (a[11:8] == 4'h1 && a[7:2] < 18) m_vec[a[7:2]][31:0] = d;
        if (a[11:8] == 4'h2 && a[7:3] < 18) m_vec[a[7:3]][32*a[2]+:32] = d;
    endfunction
    function automatic logic [31:0] m_rd(logic [11:0] a);
        int w;
        w = m_win();
        if (a[11:8] == 4'h1) begin
            return a[7:2] < 18 ? m_vec[a[7:2]][31:0] : 32'h0;
        end
        if (a[11:8] == 4'h2) begin
            return a[7:3] < 18 ? m_vec[a[7:3]][32*a[2]+:32] : 32'h0;
        end
        case (a)
            ilvc_pkg::OFS_PENDING: return m_pend;
            ilvc_pkg::OFS_ENABLE: return m_en;
            ilvc_pkg::OFS_FAST_SEL: return m_fast;
            ilvc_pkg::OFS_THRESHOLD: return m_thr;
            ilvc_pkg::OFS_VEC_INDEX:
                return w < 32 ? 32'(w) : ilvc_pkg::NO_VECTOR;
            default: return {30'h0, m_hie, m_roe};
        endcase
    endfunction
    task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er = 2'h0);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge core_clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        check(s_axi_bresp, er, "bresp");
        if (er == 2'h0) m_wr(a, d);
    endtask
    // ready is held back two cycles so the held response is exercised
    task automatic rd(logic [11:0] a, logic [1:0] er = 2'h0);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        repeat (2) @(posedge core_clk);
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(s_axi_rresp, er, "rresp");
        if (er == 2'h0) check(s_axi_rdata, m_rd(a), "rdata");
    endtask
    // vector and fast flag follow the winner even with the output off
    task automatic chk_out();
        int w;
        repeat (3) @(posedge core_clk);
        w = m_win();
        check(irq, m_roe && w < 32, "irq");
        check(vec_addr, w < 32 ? m_vec[w] : 64'h0, "vec");
        check(irq_fast, w < 32 && m_fast[w], "fast");
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        {m_en, m_pend, m_fast, m_roe, m_hie} = '0;
        m_thr = ilvc_pkg::THRESHOLD_RST;
        foreach (m_vec[i]) m_vec[i] = '0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
    endtask
    // ==========
    // scenarios
    initial begin
        void'($urandom(32'hFB26));
        do_reset();
        rd(ilvc_pkg::OFS_THRESHOLD);
        rd(ilvc_pkg::OFS_MASTER);
        rd(12'h004, ilvc_pkg::RESP_SLVERR);
        wr(12'h004, 32'h1, ilvc_pkg::RESP_SLVERR);
        for (int i = 0; i < 20; i++) begin
            wr(12'h100 + 12'(4 * i), $urandom());
            wr(12'h204 + 12'(8 * i), $urandom());
            rd(12'h100 + 12'(4 * i));
            rd(12'h204 + 12'(8 * i));
        end
        wr(ilvc_pkg::OFS_ENABLE, 32'h3FFFF);
        wr(ilvc_pkg::OFS_FAST_SEL, $urandom());
        wr(ilvc_pkg::OFS_PENDING, 32'h28);
        chk_out();
        wr(ilvc_pkg::OFS_MASTER, 32'h1);
        chk_out();
        check(jump_reg, m_vec[3], "jump");
        rd(ilvc_pkg::OFS_PENDING);
        rd(ilvc_pkg::OFS_ENABLE);
        rd(ilvc_pkg::OFS_FAST_SEL);
        for (int t = 0; t < 7; t++) begin
            wr(ilvc_pkg::OFS_THRESHOLD, 32'(t));
            rd(ilvc_pkg::OFS_THRESHOLD);
            rd(ilvc_pkg::OFS_VEC_INDEX);
            chk_out();
        end
        // a single byte lane must leave the other bytes alone
        s_axi_wstrb <= 4'h2;
        wr(ilvc_pkg::OFS_THRESHOLD, 32'h0505);
        s_axi_wstrb <= 4'hF;
        rd(ilvc_pkg::OFS_THRESHOLD);
        wr(ilvc_pkg::OFS_ACK, 32'h8);
        wr(ilvc_pkg::OFS_THRESHOLD, 32'h5);
        chk_out();
        wr(ilvc_pkg::OFS_THRESHOLD, 32'h6);
        chk_out();
        wr(ilvc_pkg::OFS_MASTER, 32'h0);
        chk_out();
        wr(ilvc_pkg::OFS_ACK, 32'h3FFFF);
        wr(ilvc_pkg::OFS_THRESHOLD, ilvc_pkg::THRESHOLD_RST);
        wr(ilvc_pkg::OFS_MASTER, 32'h3);
        wr(ilvc_pkg::OFS_MASTER, 32'h1);
        rd(ilvc_pkg::OFS_MASTER);
        wr(ilvc_pkg::OFS_PENDING, 32'h10004);
        chk_out();
        for (int k = 0; k < 8; k++) begin
            wr(ilvc_pkg::OFS_ACK, 32'h3FFFF);
            hw_irq <= 16'($urandom());
            chk_out();
            hw_irq <= '0;
        end
        do_reset();
        rd(ilvc_pkg::OFS_MASTER);
        chk_out();
        test_done();
    end
endmodule
